// ### cli_regs.svh
// offsets, field positions, reset values and timing counts of the engine
`ifndef CLI_REGS_SVH
`define CLI_REGS_SVH

// register byte addresses
`define CLI_ADR_INSTR     8'h00
`define CLI_ADR_DATA      8'h04
`define CLI_ADR_STATE     8'h08

// status word fields
`define CLI_BUSY_BIT      7

// state word fields
`define CLI_ST_DISP_ON    0
`define CLI_ST_CURSOR     1
`define CLI_ST_BLINK      2
`define CLI_ST_ENTRY_INC  3
`define CLI_ST_SHIFT_WR   4
`define CLI_ST_PAGE_EXT   5
`define CLI_ST_TWO_LINE   6
`define CLI_ST_GLYPH_SEL  7
`define CLI_ST_PAN_LSB    8
`define CLI_ST_OSC_SAFE   14

// memory contents and pointer geometry
`define CLI_BLANK         8'h20
`define CLI_LINE1_LAST    7'h27
`define CLI_LINE2_BASE    7'h40
`define CLI_LINE2_LAST    7'h67
`define CLI_PAN_LAST      6'd39

// timing
`define CLI_CLK_PERIOD_NS 20
`define CLI_OSC_PERIOD_NS 4000
`define CLI_OSC_DIV       \
    ((`CLI_OSC_PERIOD_NS + `CLI_CLK_PERIOD_NS - 1) / `CLI_CLK_PERIOD_NS)
`define CLI_SHORT_OSC     3
`define CLI_CLEAR_OSC     165
`define CLI_GROUND_OSC    3
`define CLI_BLINK_OSC     52224
`define CLI_SHORT_CLKS    (`CLI_SHORT_OSC * `CLI_OSC_DIV)
`define CLI_GROUND_CLKS   (`CLI_GROUND_OSC * `CLI_OSC_DIV)

`endif

// ### cli_pkg.sv
// types shared by the character display instruction engine
package cli_pkg;

    typedef enum logic [3:0] {
        CMD_NOP,
        CMD_CLEAR,
        CMD_HOME,
        CMD_ENTRY,
        CMD_DISPCTL,
        CMD_SHIFT,
        CMD_FUNCSET,
        CMD_GLYPHPTR,
        CMD_TEXTPTR,
        CMD_IGNORE
    } cli_cmd_t;

endpackage

// ### cli_engine.sv
// character display instruction engine with a wishbone register port
//
// Functional notes
// - busy blocks acceptance of further instructions
// - status read gives busy and pointer
// - one pointer for both memories, auto-steps
// - data read returns byte of selected memory
// - read drives data register, then steps, reloads
// - only set-address and reads load data register
// - write stores byte, pointer follows entry direction
// - glyph memory keeps only five low bits
// - clear fills text memory with blank code
// - clear zeroes pointer, pan, forces increment
// - clear takes 165 oscillator cycles
// - home zeroes pointer and pan, selects text memory
// - entry-mode bit one selects increment
// - cursor and blink hidden during glyph access
// - shift-on-write pans display on text writes
// - display control bits; off grounds outputs
// - three oscillator cycles before oscillator may stop
// - blink toggles at oscillator over 26112
// - shift instruction moves cursor or pans display
// - two-line cursor shift wraps after position 39
// - pan keeps pointer, cursor move steps it
// - standard instructions other than function set decoded only on page zero
// - pointer seven bits, all read back
`timescale 1ns/1ps
`include "cli_regs.svh"

module cli_engine #(
    parameter int CLEAR_CLKS      = `CLI_CLEAR_OSC * `CLI_OSC_DIV,
    parameter int BLINK_HALF_CLKS = (`CLI_BLINK_OSC / 2) * `CLI_OSC_DIV
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // wishbone slave
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [7:0]  wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbDatI,
    output logic      [31:0] wbDatO,
    output logic             wbAck,
    // display side
    output logic             lcdDriveEnable,
    output logic             oscStopSafe,
    output logic             cursorUnderline,
    output logic             blinkAllDots,
    output logic      [6:0]  cursorAddr,
    output logic      [5:0]  panOffset
);

    if (CLEAR_CLKS < `CLI_SHORT_CLKS || CLEAR_CLKS >= 2 ** 24) begin : g_bad1
        $error("clear count out of range");
    end
    if (BLINK_HALF_CLKS < 1 || BLINK_HALF_CLKS >= 2 ** 24) begin : g_bad2
        $error("blink count out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0]        textMem [128];
    logic [4:0]        glyphMem [64];
    logic [6:0]        ptr;
    logic [6:0]        next_ptr;
    logic              glyphSel;
    logic              next_glyphSel;
    logic [7:0]        dataReg;
    logic [23:0]       busyCnt;
    logic              busy;
    logic              entryInc;
    logic              shiftOnWrite;
    logic              displayOn;
    logic              cursorShow;
    logic              blinkOn;
    logic              pageExt;
    logic              twoLine;
    logic [9:0]        groundCnt;
    logic [23:0]       blinkCnt;
    logic              blinkPhase;
    logic              accept;
    logic              isInstr;
    logic              isData;
    logic              instrGo;
    logic              dataWrGo;
    logic              dataRdGo;
    cli_pkg::cli_cmd_t cmd;
    logic [31:0]       readback;

    function automatic cli_pkg::cli_cmd_t decodeCmd(input logic [7:0] c,
                                                    input logic       ext);
        cli_pkg::cli_cmd_t r;
        r = cli_pkg::CMD_NOP;
        if (c[7:5] == 3'b001) begin
            r = cli_pkg::CMD_FUNCSET;
        end else if (c == 8'h00) begin
            r = cli_pkg::CMD_NOP;
        end else if (ext) begin
            r = cli_pkg::CMD_IGNORE;
        end else if (c[7]) begin
            r = cli_pkg::CMD_TEXTPTR;
        end else if (c[6]) begin
            r = cli_pkg::CMD_GLYPHPTR;
        end else if (c[4] && c[1:0] == 2'b00) begin
            r = cli_pkg::CMD_SHIFT;
        end else if (c[4]) begin
            r = cli_pkg::CMD_IGNORE;
        end else if (c[3]) begin
            r = cli_pkg::CMD_DISPCTL;
        end else if (c[2]) begin
            r = cli_pkg::CMD_ENTRY;
        end else if (c[1]) begin
            r = cli_pkg::CMD_HOME;
        end else begin
            r = cli_pkg::CMD_CLEAR;
        end
        return r;
    endfunction

    function automatic logic [7:0] memRead(input logic       g,
                                           input logic [6:0] p);
        logic [7:0] r;
        r = g ? {3'h0, glyphMem[p[5:0]]} : textMem[p];
        return r;
    endfunction

    function automatic logic [6:0] stepCursor(input logic [6:0] p,
                                              input logic       right,
                                              input logic       wrap);
        logic [6:0] r;
        r = right ? p + 7'h01 : p - 7'h01;
        if (wrap && right) begin
            if (p == `CLI_LINE1_LAST) r = `CLI_LINE2_BASE;
            if (p == `CLI_LINE2_LAST) r = 7'h00;
        end else if (wrap) begin
            if (p == `CLI_LINE2_BASE) r = `CLI_LINE1_LAST;
            if (p == 7'h00) r = `CLI_LINE2_LAST;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus decode; busy refuses instructions and data accesses
    assign accept   = wbCyc & wbStb & wbAck;
    assign isInstr  = wbAdr == `CLI_ADR_INSTR;
    assign isData   = wbAdr == `CLI_ADR_DATA;
    assign busy     = busyCnt != 24'h000000;
    assign instrGo  = accept & wbWe & wbSel[0] & isInstr & ~busy;
    assign dataWrGo = accept & wbWe & wbSel[0] & isData & ~busy;
    assign dataRdGo = accept & ~wbWe & isData & ~busy;
    assign cmd      = decodeCmd(wbDatI[7:0], pageExt);

    always_comb begin
        readback = 32'h00000000;
        case (wbAdr)
            `CLI_ADR_INSTR: begin
                readback[`CLI_BUSY_BIT] = busy;
                readback[6:0]           = ptr;
            end
            `CLI_ADR_DATA: readback[7:0] = dataReg;
            `CLI_ADR_STATE: begin
                readback[`CLI_ST_DISP_ON]   = displayOn;
                readback[`CLI_ST_CURSOR]    = cursorShow;
                readback[`CLI_ST_BLINK]     = blinkOn;
                readback[`CLI_ST_ENTRY_INC] = entryInc;
                readback[`CLI_ST_SHIFT_WR]  = shiftOnWrite;
                readback[`CLI_ST_PAGE_EXT]  = pageExt;
                readback[`CLI_ST_TWO_LINE]  = twoLine;
                readback[`CLI_ST_GLYPH_SEL] = glyphSel;
                readback[`CLI_ST_PAN_LSB +: 6] = panOffset;
                readback[`CLI_ST_OSC_SAFE]  = oscStopSafe;
            end
            default: readback = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wbAck  <= 1'b0;
            wbDatO <= 32'h00000000;
        end else begin
            wbAck <= wbCyc & wbStb & ~wbAck;
            if (wbCyc && wbStb && !wbAck) begin
                wbDatO <= readback;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // busy timer
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            busyCnt <= 24'h000000;
        end else if (instrGo && cmd == cli_pkg::CMD_CLEAR) begin
            busyCnt <= 24'(CLEAR_CLKS);
        end else if (instrGo || dataWrGo || dataRdGo) begin
            busyCnt <= 24'(`CLI_SHORT_CLKS);
        end else if (busy) begin
            busyCnt <= busyCnt - 24'h000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pointer and memory select
    always_comb begin
        next_ptr      = ptr;
        next_glyphSel = glyphSel;
        if (instrGo) begin
            case (cmd)
                cli_pkg::CMD_CLEAR, cli_pkg::CMD_HOME: begin
                    next_ptr      = 7'h00;
                    next_glyphSel = 1'b0;
                end
                cli_pkg::CMD_SHIFT: begin
                    if (!wbDatI[3]) begin
                        next_ptr = stepCursor(ptr, wbDatI[2],
                                              twoLine & ~glyphSel);
                    end
                end
                cli_pkg::CMD_GLYPHPTR: begin
                    next_ptr      = {ptr[6], wbDatI[5:0]};
                    next_glyphSel = 1'b1;
                end
                cli_pkg::CMD_TEXTPTR: begin
                    next_ptr      = wbDatI[6:0];
                    next_glyphSel = 1'b0;
                end
                default: next_ptr = ptr;
            endcase
        end else if (dataWrGo || dataRdGo) begin
            next_ptr = entryInc ? ptr + 7'h01 : ptr - 7'h01;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ptr      <= 7'h00;
            glyphSel <= 1'b0;
        end else begin
            ptr      <= next_ptr;
            glyphSel <= next_glyphSel;
        end
    end

    // prefetch register: reloads from the address the pointer moves to
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dataReg <= 8'h00;
        end else if (dataRdGo || (instrGo &&
                     (cmd == cli_pkg::CMD_GLYPHPTR ||
                      cmd == cli_pkg::CMD_TEXTPTR))) begin
            dataReg <= memRead(next_glyphSel, next_ptr);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // text and glyph memories
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 128; i++) begin
                textMem[i] <= `CLI_BLANK;
            end
            for (int i = 0; i < 64; i++) begin
                glyphMem[i] <= 5'h00;
            end
        end else if (instrGo && cmd == cli_pkg::CMD_CLEAR) begin
            for (int i = 0; i < 128; i++) begin
                textMem[i] <= `CLI_BLANK;
            end
        end else if (dataWrGo && glyphSel) begin
            glyphMem[ptr[5:0]] <= wbDatI[4:0];
        end else if (dataWrGo) begin
            textMem[ptr] <= wbDatI[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode flags
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            entryInc     <= 1'b1;
            shiftOnWrite <= 1'b0;
            displayOn    <= 1'b0;
            cursorShow   <= 1'b0;
            blinkOn      <= 1'b0;
            pageExt      <= 1'b0;
            twoLine      <= 1'b0;
        end else if (instrGo) begin
            case (cmd)
                cli_pkg::CMD_CLEAR: entryInc <= 1'b1;
                cli_pkg::CMD_ENTRY: begin
                    entryInc     <= wbDatI[1];
                    shiftOnWrite <= wbDatI[0];
                end
                cli_pkg::CMD_DISPCTL: begin
                    displayOn  <= wbDatI[2];
                    cursorShow <= wbDatI[1];
                    blinkOn    <= wbDatI[0];
                end
                cli_pkg::CMD_FUNCSET: begin
                    twoLine <= wbDatI[2];
                    pageExt <= wbDatI[0];
                end
                default: pageExt <= pageExt;
            endcase
        end
    end

    // display pan position, wraps within one line
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            panOffset <= 6'h00;
        end else if (instrGo && (cmd == cli_pkg::CMD_CLEAR ||
                                 cmd == cli_pkg::CMD_HOME)) begin
            panOffset <= 6'h00;
        end else if ((instrGo && cmd == cli_pkg::CMD_SHIFT && wbDatI[3] &&
                      !wbDatI[2]) ||
                     (dataWrGo && !glyphSel && shiftOnWrite && entryInc)) begin
            panOffset <= panOffset == `CLI_PAN_LAST ?
                         6'h00 : panOffset + 6'h01;
        end else if ((instrGo && cmd == cli_pkg::CMD_SHIFT && wbDatI[3] &&
                      wbDatI[2]) ||
                     (dataWrGo && !glyphSel && shiftOnWrite && !entryInc)) begin
            panOffset <= panOffset == 6'h00 ?
                         `CLI_PAN_LAST : panOffset - 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power-down grounding delay
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            groundCnt   <= 10'h000;
            oscStopSafe <= 1'b0;
        end else if (displayOn) begin
            groundCnt   <= 10'h000;
            oscStopSafe <= 1'b0;
        end else if (groundCnt == 10'(`CLI_GROUND_CLKS)) begin
            oscStopSafe <= 1'b1;
        end else begin
            groundCnt <= groundCnt + 10'h001;
        end
    end

    // blink phase generator
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            blinkCnt   <= 24'h000000;
            blinkPhase <= 1'b0;
        end else if (blinkCnt == 24'(BLINK_HALF_CLKS - 1)) begin
            blinkCnt   <= 24'h000000;
            blinkPhase <= ~blinkPhase;
        end else begin
            blinkCnt <= blinkCnt + 24'h000001;
        end
    end

    // display side outputs
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            lcdDriveEnable  <= 1'b0;
            cursorUnderline <= 1'b0;
            blinkAllDots    <= 1'b0;
            cursorAddr      <= 7'h00;
        end else begin
            lcdDriveEnable  <= displayOn;
            cursorUnderline <= displayOn & cursorShow & ~glyphSel;
            blinkAllDots    <= displayOn & blinkOn & blinkPhase &
                               ~glyphSel;
            cursorAddr      <= ptr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_status_req;
        wbCyc && wbStb && !wbAck && !wbWe && isInstr;
    endsequence

    sequence s_clear_go;
        instrGo && cmd == cli_pkg::CMD_CLEAR;
    endsequence

    a_busy_load: assert property (@(posedge mclk) disable iff (!rst_b)
        s_clear_go |=> busyCnt == 24'(CLEAR_CLKS))
        else $error("clear busy count wrong");

    a_busy_short: assert property (@(posedge mclk) disable iff (!rst_b)
        (dataWrGo || (instrGo && cmd != cli_pkg::CMD_CLEAR))
        |=> busy && busyCnt == 24'(`CLI_SHORT_CLKS))
        else $error("short busy count wrong");

    a_busy_ignore: assert property (@(posedge mclk) disable iff (!rst_b)
        (accept && wbWe && busy && !(wbAdr == `CLI_ADR_STATE))
        |=> $stable(ptr) && $stable(displayOn) && $stable(entryInc))
        else $error("access taken while busy");

    a_status_read: assert property (@(posedge mclk) disable iff (!rst_b)
        s_status_req |=> wbAck && wbDatO[7] == $past(busy)
        && wbDatO[6:0] == $past(ptr))
        else $error("status word wrong");

    a_write_step: assert property (@(posedge mclk) disable iff (!rst_b)
        dataWrGo |=> ptr == ($past(entryInc) ?
                             7'($past(ptr) + 7'h01) :
                             7'($past(ptr) - 7'h01)))
        else $error("pointer step after write wrong");

    a_read_reload: assert property (@(posedge mclk) disable iff (!rst_b)
        dataRdGo |=> dataReg == memRead(glyphSel, ptr))
        else $error("prefetch not reloaded");

    a_dreg_keep: assert property (@(posedge mclk) disable iff (!rst_b)
        (dataWrGo || (instrGo && (cmd == cli_pkg::CMD_CLEAR ||
         cmd == cli_pkg::CMD_HOME || cmd == cli_pkg::CMD_SHIFT)))
        |=> $stable(dataReg))
        else $error("data register disturbed");

    a_clear_effect: assert property (@(posedge mclk) disable iff (!rst_b)
        s_clear_go |=> ptr == 7'h00 && panOffset == 6'h00 && entryInc
        && textMem[0] == `CLI_BLANK && $stable(shiftOnWrite))
        else $error("clear effect wrong");

    a_pan_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
        ((dataWrGo && (glyphSel || !shiftOnWrite)) || dataRdGo)
        |=> $stable(panOffset))
        else $error("display panned without cause");

    a_ground_wait: assert property (@(posedge mclk) disable iff (!rst_b)
        $fell(displayOn) |=> !oscStopSafe ##[1:700] oscStopSafe)
        else $error("grounding delay wrong");

    a_glyph_hide: assert property (@(posedge mclk) disable iff (!rst_b)
        glyphSel |=> !cursorUnderline && !blinkAllDots)
        else $error("cursor shown during glyph access");

endmodule

// ### cli_host.sv
// wishbone master model standing in for the host controller
`timescale 1ns/1ps

module cli_host (
    // clock
    input  wire logic        mclk,
    // wishbone master
    output logic             wbCyc,
    output logic             wbStb,
    output logic             wbWe,
    output logic      [7:0]  wbAdr,
    output logic      [3:0]  wbSel,
    output logic      [31:0] wbDatI,
    input  wire logic [31:0] wbDatO,
    input  wire logic        wbAck
);
    initial begin
        wbCyc  = 1'b0;
        wbStb  = 1'b0;
        wbWe   = 1'b0;
        wbAdr  = 8'hff;
        wbSel  = 4'h0;
        wbDatI = 32'hffffffff;
    end

    // one classic cycle, request held until ack is sampled
    task automatic xfer(input logic we, input logic [7:0] adr,
                        input logic [31:0] dat, output logic [31:0] rd);
        @(posedge mclk);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbAdr  <= adr;
        wbSel  <= 4'hf;
        wbDatI <= dat;
        do @(posedge mclk); while (wbAck !== 1'b1);
        rd = wbDatO;
        wbCyc  <= 1'b0;
        wbStb  <= 1'b0;
        // released bus shows no stale value
        wbAdr  <= ~adr;
        wbDatI <= ~dat;
    endtask

    // poll until idle, then make the access
    task automatic access(input logic we, input logic [7:0] adr,
                          input logic [31:0] dat, output logic [31:0] rd);
        logic [31:0] st;
        st = 32'h80;
        while (st[7] !== 1'b0) xfer(1'b0, 8'h00, 32'h0, st);
        xfer(we, adr, dat, rd);
    endtask
endmodule

// ### char_lcd_instruction_engine_tb.sv
// self-checking bench for the instruction engine
`timescale 1ns/1ps
`include "cli_regs.svh"
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
    num_errors++; $display("[FAIL] %s exp %h got %h", nm, exp, got); end end

module char_lcd_instruction_engine_tb;
    localparam logic W = 1'b1;
    localparam logic R = 1'b0;
    logic        mclk;
    logic        rst_b;
    logic        wbCyc;
    logic        wbStb;
    logic        wbWe;
    logic [7:0]  wbAdr;
    logic [3:0]  wbSel;
    logic [31:0] wbDatI;
    logic [31:0] wbDatO;
    logic        wbAck;
    logic        lcdDriveEnable;
    logic        oscStopSafe;
    logic        cursorUnderline;
    logic        blinkAllDots;
    logic [6:0]  cursorAddr;
    logic [5:0]  panOffset;
    logic [31:0] rd;
    int          num_errors;
    int          num_checks;
    int          cycles;
    int          ones;
    // rows: direction, address, write data or expected read
    logic [24:0] rows [$] = '{
        {R,8'h08,16'h0008}, {W,8'h08,16'h00ff}, {R,8'h08,16'h0008},
        {R,8'h0c,16'h0000}, {W,8'h00,16'h0085}, {W,8'h04,16'h0041},
        {R,8'h00,16'h0006},
        {W,8'h00,16'h0085}, {R,8'h04,16'h0041},
        {R,8'h04,16'h0020}, {W,8'h00,16'h0004}, {W,8'h04,16'h0042},
        {R,8'h00,16'h0006},
        {R,8'h04,16'h0020},
        {W,8'h00,16'h0043}, {W,8'h04,16'h00ff}, {W,8'h00,16'h0043},
        {R,8'h04,16'h001f}, {R,8'h08,16'h0080},
        {W,8'h00,16'h0005}, {W,8'h00,16'h0001}, {R,8'h00,16'h0000},
        {R,8'h08,16'h0018}, {W,8'h00,16'h0087},
        {R,8'h04,16'h0020}, {R,8'h08,16'h0018},
        {W,8'h04,16'h0055}, {R,8'h08,16'h0118},
        {W,8'h00,16'h0002}, {R,8'h00,16'h0000},
        {R,8'h08,16'h0018}, {W,8'h00,16'h0006},
        {W,8'h00,16'h0018}, {R,8'h00,16'h0000},
        {W,8'h00,16'h001c}, {W,8'h00,16'h0014}, {R,8'h00,16'h0001},
        {W,8'h00,16'h0010}, {R,8'h08,16'h0008},
        {W,8'h00,16'h0021}, {W,8'h00,16'h0014},
        {R,8'h00,16'h0000}, {W,8'h00,16'h0024}, {W,8'h00,16'h00a7},
        {W,8'h00,16'h0014}, {R,8'h00,16'h0040},
        {W,8'h00,16'h0010}, {R,8'h00,16'h0027},
        {W,8'h00,16'h000f}, {R,8'h08,16'h004f}
    };

    cli_engine #(.CLEAR_CLKS(700), .BLINK_HALF_CLKS(16)) u_cli_engine (
        .mclk(mclk), .rst_b(rst_b), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI),
        .wbDatO(wbDatO), .wbAck(wbAck), .lcdDriveEnable(lcdDriveEnable),
        .oscStopSafe(oscStopSafe), .cursorUnderline(cursorUnderline),
        .blinkAllDots(blinkAllDots), .cursorAddr(cursorAddr),
        .panOffset(panOffset));

    cli_host u_cli_host (
        .mclk(mclk), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO),
        .wbAck(wbAck));

    always #10 mclk = ~mclk;

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic final_report();
        if (num_errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        rst_b = 1'b0;
        num_errors = 0;
        num_checks = 0;
        cycles = 0;
        repeat (2) @(posedge mclk);
        `CHK("reset ack", 1'b0, wbAck)
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            u_cli_host.access(rows[i][24], rows[i][23:16],
                              {16'h0, rows[i][15:0]}, rd);
            if (!rows[i][24])
                `CHK("row read", rows[i][13:0], rd[13:0])
        end
        repeat (2) @(posedge mclk);
        `CHK("underline", 1'b1, cursorUnderline)
        `CHK("drive on", 1'b1, lcdDriveEnable)
        ones = 0;
        repeat (64) @(negedge mclk) ones += (blinkAllDots === 1'b1);
        `CHK("blink ones", 32, ones)
        u_cli_host.access(W, 8'h00, 32'h40, rd);
        repeat (2) @(posedge mclk);
        `CHK("glyph underline", 1'b0, cursorUnderline)
        u_cli_host.access(W, 8'h00, 32'h85, rd);
        u_cli_host.xfer(R, 8'h00, 32'h0, rd);
        `CHK("busy set", 1'b1, rd[7])
        u_cli_host.xfer(W, 8'h00, 32'h80, rd);
        u_cli_host.access(R, 8'h00, 32'h0, rd);
        `CHK("refused ptr", 8'h05, rd[7:0])
        `CHK("cursor addr", 7'h05, cursorAddr)
        u_cli_host.access(W, 8'h00, 32'h01, rd);
        repeat (650) @(posedge mclk);
        u_cli_host.xfer(R, 8'h00, 32'h0, rd);
        `CHK("clear busy", 1'b1, rd[7])
        repeat (80) @(posedge mclk);
        u_cli_host.xfer(R, 8'h00, 32'h0, rd);
        `CHK("clear done", 1'b0, rd[7])
        u_cli_host.access(W, 8'h00, 32'h08, rd);
        repeat (2) @(posedge mclk);
        `CHK("drive off", 1'b0, lcdDriveEnable)
        `CHK("osc early", 1'b0, oscStopSafe)
        repeat (`CLI_GROUND_CLKS + 5) @(posedge mclk);
        `CHK("osc safe", 1'b1, oscStopSafe)
        rst_b <= 1'b0;
        @(negedge mclk);
        `CHK("reset ptr", 7'h00, cursorAddr)
        `CHK("reset pan", 6'h00, panOffset)
        final_report();
    end
endmodule
